//--- hdl/residual_current_limit_monitor.sv
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "rcm_defines.svh"
module residual_current_limit_monitor
    import rcm_pkg::*;
#(
    parameter int DW         = 16,
    parameter int NUM_STEPS  = 10,
    parameter int SCALE_FRAC = 8,
    parameter int TIME_W     = 16,
    parameter int TICK_CYC   = `TIME_UNIT_NS / `CLK_PERIOD_NS
) (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic [7:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    input  wire logic [3:0]    avs_byteenable,
    output logic      [31:0]   avs_readdata,
    output logic               avs_waitrequest,
    input  wire logic [DW-1:0] rc_value,
    input  wire logic [DW-1:0] ref_multifunc,
    input  wire logic [DW-1:0] ref_base,
    input  wire logic [DW-1:0] ref_module,
    input  wire logic          cable_fault,
    output flags_t             flags,
    output logic               irq
);

    generate
        if (DW < 8 || DW > 32 || NUM_STEPS < 1 || NUM_STEPS > 15 ||
            TIME_W > 32 || TICK_CYC < 1) begin : g_bad
            $error("residual_current_limit_monitor: bad parameters");
        end
    endgenerate

    localparam int TCW = $clog2(TICK_CYC + 1);

    // ****************************************
    // Register storage
    // ****************************************
    ctrl_t             ctrl_reg;
    logic [DW-1:0]     static_lim_reg;
    logic [DW-1:0]     offset_reg;
    logic [DW-1:0]     scale_reg;
    logic [7:0]        pct_reg;
    logic [TIME_W-1:0] min_time_reg;
    logic [DW-1:0]     thr_mem [NUM_STEPS];
    logic [DW-1:0]     ofs_mem [NUM_STEPS];
    flags_t            irq_stat_reg;
    flags_t            irq_mask_reg;
    logic              wait_reg;
    logic [31:0]       rdata_reg;
    logic              acc;
    logic              wr_acc;
    logic [31:0]       wmerge;
    logic [31:0]       rd_next;
    logic [3:0]        bank_idx;
    logic              in_bank;

    // ****************************************
    // Datapath state
    // ****************************************
    logic [DW-1:0]     ref_reg;
    logic [DW-1:0]     rc_reg;
    logic [DW-1:0]     limit_reg;
    logic [DW-1:0]     limit_next;
    logic [DW-1:0]     warn_lim_reg;
    logic [DW-1:0]     warn_lim_next;
    logic [TCW-1:0]    tick_div_reg;
    logic              tick;
    logic [TIME_W-1:0] exceed_cnt_reg;
    flags_t            flags_reg;
    flags_t            flags_prev_reg;
    logic              alarm_ack;
    logic              irq_reg;

    function automatic logic [31:0] be_merge(input logic [31:0] o,
                                             input logic [31:0] n,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = n[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************
    // Avalon slave handshake
    // ****************************************
    assign acc      = (avs_read || avs_write) && wait_reg;
    assign wr_acc   = avs_write && !wait_reg;
    assign bank_idx = avs_address[5:2];
    assign in_bank  = (avs_address[1:0] == 2'h0) &&
                      (32'(bank_idx) < NUM_STEPS);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            wait_reg <= !acc;
            if (acc && avs_read) begin
                rdata_reg <= rd_next;
            end
        end
    end

    always_comb begin
        rd_next = 32'h0000_0000;
        case (avs_address)
            `REG_CTRL:       rd_next = 32'(ctrl_reg);
            `REG_STATIC_LIM: rd_next = 32'(static_lim_reg);
            `REG_OFFSET:     rd_next = 32'(offset_reg);
            `REG_SCALE:      rd_next = 32'(scale_reg);
            `REG_WARN_PCT:   rd_next = 32'(pct_reg);
            `REG_MIN_TIME:   rd_next = 32'(min_time_reg);
            `REG_FLAGS:      rd_next = 32'(flags_reg);
            `REG_IRQ_STAT:   rd_next = 32'(irq_stat_reg);
            `REG_IRQ_MASK:   rd_next = 32'(irq_mask_reg);
            `REG_LIMIT:      rd_next = 32'(limit_reg);
            `REG_WARN_LIM:   rd_next = 32'(warn_lim_reg);
            default: begin
                if (in_bank && avs_address[7:6] == `BANK_THR) begin
                    rd_next = 32'(thr_mem[bank_idx]);
                end else if (in_bank && avs_address[7:6] == `BANK_OFS) begin
                    rd_next = 32'(ofs_mem[bank_idx]);
                end
            end
        endcase
        wmerge = be_merge(rd_next, avs_writedata, avs_byteenable);
    end

    // ****************************************
    // Configuration writes
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg       <= ctrl_t'(`CTRL_RST);
            static_lim_reg <= '0;
            offset_reg     <= '0;
            scale_reg      <= '0;
            pct_reg        <= `WARN_PCT_RST;
            min_time_reg   <= '0;
            irq_mask_reg   <= '0;
        end else if (wr_acc) begin
            case (avs_address)
                `REG_CTRL:       ctrl_reg       <= ctrl_t'(wmerge[10:0]);
                `REG_STATIC_LIM: static_lim_reg <= wmerge[DW-1:0];
                `REG_OFFSET:     offset_reg     <= wmerge[DW-1:0];
                `REG_SCALE:      scale_reg      <= wmerge[DW-1:0];
                `REG_WARN_PCT:   pct_reg        <= wmerge[7:0];
                `REG_MIN_TIME:   min_time_reg   <= wmerge[TIME_W-1:0];
                `REG_IRQ_MASK:   irq_mask_reg   <= flags_t'(wmerge[3:0]);
                default:         ;
            endcase
        end
    end

    // Step tables, no ordering enforced
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_STEPS; i++) begin
                thr_mem[i] <= '0;
                ofs_mem[i] <= '0;
            end
        end else if (wr_acc && in_bank) begin
            if (avs_address[7:6] == `BANK_THR) begin
                thr_mem[bank_idx] <= wmerge[DW-1:0];
            end else if (avs_address[7:6] == `BANK_OFS) begin
                ofs_mem[bank_idx] <= wmerge[DW-1:0];
            end
        end
    end

    // ****************************************
    // Limit computation
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_reg <= '0;
            rc_reg  <= '0;
        end else begin
            rc_reg <= rc_value;
            case (ctrl_reg.ref_src)
                REF_MULTIFUNC: ref_reg <= ref_multifunc;
                REF_BASE:      ref_reg <= ref_base;
                REF_MODULE:    ref_reg <= ref_module;
                default:       ref_reg <= ref_multifunc;
            endcase
        end
    end

    always_comb begin
        logic [2*DW:0]   sum;
        logic [2*DW-1:0] prod;
        logic [DW-1:0]   step_ofs;
        sum      = '0;
        prod     = (2*DW)'(ref_reg) * (2*DW)'(scale_reg);
        step_ofs = '0;
        for (int i = 0; i < NUM_STEPS; i++) begin
            if (i < 32'(ctrl_reg.num_steps) && ref_reg > thr_mem[i]) begin
                step_ofs = ofs_mem[i];
            end
        end
        case (ctrl_reg.mode)
            LIM_STATIC:   sum = (2*DW+1)'(static_lim_reg);
            LIM_DYNAMIC:  sum = (2*DW+1)'(prod >> SCALE_FRAC) +
                                (2*DW+1)'(offset_reg);
            LIM_STEPWISE: sum = (2*DW+1)'(offset_reg) +
                                (2*DW+1)'(step_ofs);
            default:      sum = (2*DW+1)'(static_lim_reg);
        endcase
        if (sum[2*DW:DW] != '0) begin
            limit_next = '1;
        end else begin
            limit_next = sum[DW-1:0];
        end
        warn_lim_next = DW'((limit_reg * pct_reg) / `PCT_DIV);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            limit_reg    <= '0;
            warn_lim_reg <= '0;
        end else begin
            limit_reg    <= limit_next;
            warn_lim_reg <= warn_lim_next;
        end
    end

    // ****************************************
    // Exceedance timer
    // ****************************************
    assign tick = (tick_div_reg == TCW'(TICK_CYC - 1));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_div_reg <= '0;
        end else if (tick) begin
            tick_div_reg <= '0;
        end else begin
            tick_div_reg <= tick_div_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            exceed_cnt_reg <= '0;
        end else if (!flags_reg.over) begin
            exceed_cnt_reg <= '0;
        end else if (tick && exceed_cnt_reg != '1) begin
            exceed_cnt_reg <= exceed_cnt_reg + 1'b1;
        end
    end

    // ****************************************
    // Flags
    // ****************************************
    assign alarm_ack = wr_acc && avs_address == `REG_FLAGS &&
                       avs_byteenable[0] && avs_writedata[`FLAG_ALARM];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg      <= '0;
            flags_prev_reg <= '0;
        end else begin
            flags_prev_reg   <= flags_reg;
            flags_reg.warn   <= rc_reg > warn_lim_reg;
            flags_reg.over   <= rc_reg > limit_reg;
            flags_reg.cable_break <= ctrl_reg.cable_en && cable_fault &&
                (ctrl_reg.xfmr == XF_PASSIVE_AC ||
                 ctrl_reg.xfmr == XF_LOOP_4_20);
            if (flags_reg.over && exceed_cnt_reg > min_time_reg) begin
                flags_reg.alarm <= 1'b1;
            end else if (alarm_ack) begin
                flags_reg.alarm <= 1'b0;
            end
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= '0;
            irq_reg      <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg &
                             ~((wr_acc && avs_address == `REG_IRQ_STAT) ?
                               flags_t'(avs_writedata[3:0] &
                                        {4{avs_byteenable[0]}}) :
                               flags_t'(4'h0))) |
                            (flags_reg & ~flags_prev_reg);
            irq_reg      <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign flags           = flags_reg;
    assign irq             = irq_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_static_limit;
        ctrl_reg.mode == LIM_STATIC && $stable(static_lim_reg)
            |=> limit_reg == $past(static_lim_reg);
    endproperty
    a_static_limit: assert property (p_static_limit)
        else $error("static limit not applied");
    property p_dyn_offset;
        ctrl_reg.mode == LIM_DYNAMIC && scale_reg == '0
            |=> limit_reg == $past(offset_reg);
    endproperty
    a_dyn_offset: assert property (p_dyn_offset)
        else $error("dynamic limit without scale not offset");
    property p_step_none;
        ctrl_reg.mode == LIM_STEPWISE && ctrl_reg.num_steps == 4'h0
            |=> limit_reg == $past(offset_reg);
    endproperty
    a_step_none: assert property (p_step_none)
        else $error("stepwise limit without steps not offset");
    property p_over_follow;
        rc_reg > limit_reg |=> flags.over;
    endproperty
    a_over_follow: assert property (p_over_follow)
        else $error("overcurrent flag missing");
    property p_over_clear;
        rc_reg <= limit_reg |=> !flags.over;
    endproperty
    a_over_clear: assert property (p_over_clear)
        else $error("overcurrent flag not cleared");
    property p_warn_track;
        ##1 flags.warn == $past(rc_reg > warn_lim_reg);
    endproperty
    a_warn_track: assert property (p_warn_track)
        else $error("warning flag wrong");
    property p_alarm_cause;
        $rose(flags.alarm) |-> $past(flags_reg.over) &&
            $past(exceed_cnt_reg > min_time_reg);
    endproperty
    a_alarm_cause: assert property (p_alarm_cause)
        else $error("alarm raised too early");
    property p_alarm_latch;
        flags.alarm && !alarm_ack |=> flags.alarm;
    endproperty
    a_alarm_latch: assert property (p_alarm_latch)
        else $error("alarm dropped without acknowledge");
    property p_timer_restart;
        !flags_reg.over |=> exceed_cnt_reg == '0;
    endproperty
    a_timer_restart: assert property (p_timer_restart)
        else $error("exceedance timer not restarted");
    property p_cable_gate;
        !ctrl_reg.cable_en || ctrl_reg.xfmr == XF_ACTIVE
            |=> !flags.cable_break;
    endproperty
    a_cable_gate: assert property (p_cable_gate)
        else $error("cable break flagged while not supervised");
    property p_warn_level;
        $stable(limit_reg) && $stable(pct_reg)
            |=> warn_lim_reg == DW'(($past(limit_reg) * $past(pct_reg))
                                    / `PCT_DIV);
    endproperty
    a_warn_level: assert property (p_warn_level)
        else $error("warning level wrong");

    c_alarm:  cover property ($rose(flags.alarm));
    c_step:   cover property (ctrl_reg.mode == LIM_STEPWISE && flags.over);
    c_cable:  cover property ($rose(flags.cable_break));
    c_ack:    cover property (flags.alarm && alarm_ack ##1 !flags.alarm);

endmodule // residual_current_limit_monitor

//--- hdl/rcm_defines.svh
`ifndef RCM_DEFINES_SVH
`define RCM_DEFINES_SVH

// ****************************************
// Register byte offsets and step table bank codes
// ****************************************
`define REG_CTRL        8'h00
`define REG_STATIC_LIM  8'h04
`define REG_OFFSET      8'h08
`define REG_SCALE       8'h0C
`define REG_WARN_PCT    8'h10
`define REG_MIN_TIME    8'h14
`define REG_FLAGS       8'h18
`define REG_IRQ_STAT    8'h1C
`define REG_IRQ_MASK    8'h20
`define REG_LIMIT       8'h24
`define REG_WARN_LIM    8'h28
`define BANK_THR        2'h1
`define BANK_OFS        2'h2

// ****************************************
// Field positions and reset values
// ****************************************
`define FLAG_ALARM      1
`define CTRL_RST        11'h000
`define WARN_PCT_RST    8'h50
`define PCT_DIV         100

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS   8
`define TIME_UNIT_NS    1000000

`endif

//--- hdl/rcm_pkg.sv
package rcm_pkg;

    typedef enum logic [1:0] {
        LIM_STATIC   = 2'h0,
        LIM_DYNAMIC  = 2'h1,
        LIM_STEPWISE = 2'h2
    } limit_mode_t;

    typedef enum logic [1:0] {
        REF_MULTIFUNC = 2'h0,
        REF_BASE      = 2'h1,
        REF_MODULE    = 2'h2
    } ref_src_t;

    typedef enum logic [1:0] {
        XF_PASSIVE_AC = 2'h0,
        XF_LOOP_4_20  = 2'h1,
        XF_ACTIVE     = 2'h2
    } xfmr_t;

    typedef struct packed {
        logic [3:0]  num_steps;
        logic        cable_en;
        xfmr_t       xfmr;
        ref_src_t    ref_src;
        limit_mode_t mode;
    } ctrl_t;

    typedef struct packed {
        logic cable_break;
        logic alarm;
        logic over;
        logic warn;
    } flags_t;

endpackage

//--- bench/meas_channel_model.sv
`timescale 1ns/1ps
// ****************
// Measurement channel model
// ****************
module meas_channel_model #(
    parameter int DW = 16
) (
    input  wire logic          core_clk,
    output logic      [DW-1:0] rc_value,
    output logic      [DW-1:0] ref_multifunc,
    output logic      [DW-1:0] ref_base,
    output logic      [DW-1:0] ref_module,
    output logic               cable_fault
);
    initial begin
        rc_value      = '0;
        ref_multifunc = '0;
        ref_base      = '0;
        ref_module    = '0;
        cable_fault   = 1'b0;
    end

    // Present new levels right after a rising edge
    task automatic drive(input logic [DW-1:0] rc, r0, r1, r2,
                         input logic cf);
        @(posedge core_clk);
        rc_value      <= rc;
        ref_multifunc <= r0;
        ref_base      <= r1;
        ref_module    <= r2;
        cable_fault   <= cf;
    endtask
endmodule // meas_channel_model

//--- bench/tb_top.sv
`timescale 1ns/1ps
`include "rcm_defines.svh"
// ****************
// Testbench
// ****************
module tb_top
    import rcm_pkg::*;
;
    localparam int TICK   = 4;
    localparam int MINT   = 3;
    localparam int SETTLE = 6;

    logic        core_clk;
    logic        rst_n;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [15:0] rc_value;
    logic [15:0] ref_multifunc;
    logic [15:0] ref_base;
    logic [15:0] ref_module;
    logic        cable_fault;
    flags_t      flags;
    logic        irq;
    int          errors;
    int          checks;
    int          it;
    int          i;
    int          n;
    logic [31:0] lfsr;
    logic [31:0] rdat;
    logic [15:0] thr [10];
    logic [15:0] ofs [10];
    logic [15:0] r [3];
    logic [15:0] sl, off, sc, lim, wl, rc, t16;
    logic [1:0]  m, src;
    logic [3:0]  ns;
    logic [7:0]  pct;

    always #4 core_clk = ~core_clk;

    residual_current_limit_monitor #(.TICK_CYC(TICK)) DUT (
        .core_clk        (core_clk),
        .rst_n           (rst_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .rc_value        (rc_value),
        .ref_multifunc   (ref_multifunc),
        .ref_base        (ref_base),
        .ref_module      (ref_module),
        .cable_fault     (cable_fault),
        .flags           (flags),
        .irq             (irq)
    );

    meas_channel_model #(.DW(16)) u_meas (
        .core_clk      (core_clk),
        .rc_value      (rc_value),
        .ref_multifunc (ref_multifunc),
        .ref_base      (ref_base),
        .ref_module    (ref_module),
        .cable_fault   (cable_fault)
    );

    // ****************
    // Helpers
    // ****************
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[15:0];
    endfunction

    function automatic logic [15:0] exp_lim(input logic [1:0] md,
        input logic [15:0] rv, s, o, k, input logic [3:0] cnt);
        logic [31:0] t;
        int          j;
        t = {16'h0000, o};
        if (md == 2'h0) return s;
        if (md == 2'h1) t = ((rv * k) >> 8) + o;
        else for (j = 0; j < cnt && j < 10; j++)
            if (rv > thr[j]) t = {16'h0000, o} + ofs[j];
        return (t > 32'h0000_ffff) ? 16'hffff : t[15:0];
    endfunction

    function automatic logic [15:0] exp_warn(input logic [15:0] l,
                                              input logic [7:0] p);
        logic [31:0] w;
        w = ({16'h0000, l} * {24'h00_0000, p}) / 32'h0000_0064;
        return w[15:0];
    endfunction

    task automatic stop_test();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic rd, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int k;
        @(posedge core_clk);
        avs_read       <= rd;
        avs_write      <= !rd;
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (k == 20) begin
            errors++;
            $display("ERROR %0t: bus timeout", $time);
            stop_test();
        end
        rdat = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b0, a, d, 4'hf);
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b1, a, 32'h0000_0000, 4'hf);
        chk(rdat, e);
    endtask

    task automatic settle();
        repeat (SETTLE) @(posedge core_clk);
    endtask

    initial begin
        #800000;
        errors++;
        $display("ERROR %0t: run timeout", $time);
        stop_test();
    end

    // ****************
    // Main sequence
    // ****************
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = '0;
        lfsr = 32'h0000_0bb8;
        errors = 0;
        checks = 0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        chk({27'h0, flags, irq}, 32'h0000_0000);
        reg_rd(`REG_CTRL, 32'h0000_0000);
        reg_rd(`REG_WARN_PCT, 32'h0000_0050);
        reg_wr(8'h3c, 32'hffff_ffff);
        reg_rd(8'h3c, 32'h0000_0000);
        reg_wr(`REG_LIMIT, 32'h0000_1234);
        bus(1'b0, `REG_STATIC_LIM, 32'h0000_abcd, 4'h1);
        reg_rd(`REG_STATIC_LIM, 32'h0000_00cd);
        settle();
        reg_rd(`REG_LIMIT, 32'h0000_00cd);

        // Random limit configurations in every mode and source
        for (it = 0; it < 18; it++) begin
            m = 2'(it % 3);
            src = 2'((it / 3) % 3);
            t16 = rnd() % 16'h000b;
            ns = (it == 2) ? 4'h0 : (it == 5) ? 4'ha : t16[3:0];
            sl = rnd();
            off = rnd() & 16'h0fff;
            sc = rnd();
            if (it == 4) sc = 16'h0000;
            t16 = rnd() % 16'h0065;
            pct = t16[7:0];
            t16 = 16'h0000;
            for (i = 0; i < 10; i++) begin
                t16 = t16 + (rnd() & 16'h0fff) + 16'h0001;
                thr[i] = t16;
                ofs[i] = rnd() & 16'h3fff;
                reg_wr(8'h40 + 8'(i * 4), {16'h0000, thr[i]});
                reg_wr(8'h80 + 8'(i * 4), {16'h0000, ofs[i]});
            end
            reg_wr(`REG_STATIC_LIM, {16'h0000, sl});
            reg_wr(`REG_OFFSET, {16'h0000, off});
            reg_wr(`REG_SCALE, {16'h0000, sc});
            reg_wr(`REG_WARN_PCT, {24'h00_0000, pct});
            reg_wr(`REG_CTRL, {21'h0, ns, 1'b0, 2'b00, src, m});
            for (i = 0; i < 3; i++) r[i] = rnd();
            lim = exp_lim(m, r[src], sl, off, sc, ns);
            wl = exp_warn(lim, pct);
            case (it % 4)
                0: rc = lim;
                1: rc = lim + 16'(lim != 16'hffff);
                2: rc = wl + 16'(wl != 16'hffff);
                default: rc = rnd();
            endcase
            u_meas.drive(rc, r[0], r[1], r[2], 1'b0);
            settle();
            reg_rd(`REG_LIMIT, {16'h0000, lim});
            reg_rd(`REG_WARN_LIM, {16'h0000, wl});
            chk({31'h0, flags.over}, {31'h0, rc > lim});
            chk({31'h0, flags.warn}, {31'h0, rc > wl});
        end

        // Alarm qualification, latching and interrupts
        reg_wr(`REG_CTRL, 32'h0000_0000);
        reg_wr(`REG_STATIC_LIM, 32'h0000_0064);
        reg_wr(`REG_WARN_PCT, 32'h0000_0032);
        reg_wr(`REG_MIN_TIME, MINT);
        reg_wr(`REG_IRQ_MASK, 32'h0000_0004);
        u_meas.drive(16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0);
        settle();
        reg_wr(`REG_FLAGS, 32'h0000_0002);
        reg_wr(`REG_IRQ_STAT, 32'h0000_000f);
        settle();
        chk({27'h0, flags, irq}, 32'h0000_0000);
        u_meas.drive(16'h00c8, 16'h0000, 16'h0000, 16'h0000, 1'b0);
        for (i = 0; i < 12; i++) begin
            @(posedge core_clk);
            chk({30'h0, flags.alarm, irq}, 32'h0000_0000);
        end
        u_meas.drive(16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0);
        repeat (4) @(posedge core_clk);
        u_meas.drive(16'h00c8, 16'h0000, 16'h0000, 16'h0000, 1'b0);
        for (n = 0; n < 100; n++) begin
            @(posedge core_clk);
            if (flags.alarm === 1'b1) break;
        end
        chk({31'h0, n >= MINT * TICK + 2}, 32'h0000_0001);
        chk({31'h0, n <= (MINT + 2) * TICK + 6}, 32'h0000_0001);
        repeat (3) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0000_0001);
        u_meas.drive(16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0);
        settle();
        chk({28'h0, flags}, 32'h0000_0004);
        reg_rd(`REG_IRQ_STAT, 32'h0000_0007);
        reg_wr(`REG_IRQ_STAT, 32'h0000_0004);
        settle();
        chk({31'h0, irq}, 32'h0000_0000);
        reg_rd(`REG_IRQ_STAT, 32'h0000_0003);
        reg_wr(`REG_FLAGS, 32'h0000_0002);
        settle();
        reg_rd(`REG_FLAGS, 32'h0000_0000);

        // Cable break supervision per transformer kind
        for (i = 0; i < 4; i++) begin
            reg_wr(`REG_CTRL, (i < 3) ? 32'h40 | (i << 4) : 32'h0);
            u_meas.drive(16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b1);
            settle();
            chk({31'h0, flags.cable_break}, {31'h0, i < 2});
        end
        u_meas.drive(16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0);
        settle();
        stop_test();
    end
endmodule // tb_top
